// ===== logic/spo_synth_ctrl.sv
// Purpose: synthesiser pin override, oscillator trim and synthesiser reset
// Assumes: register port decoded from the serial front end on clk_sys
// Notes:   pin inputs pass two flops; all outputs are registered
//
// Summary of operation
// - override enable 0: enable, ref type, both outputs follow the pins
// - override enable bit 7 set: pins ignored, register fields used
// - bits 5:4 set second output: off, divide 1, 2 or 4
// - bits 3:2 set first output: off, divide 1, 2 or 4
// - with override off, mode field writes do not reach the outputs
// - second output stays off unless the first output runs
// - override bit 1 selects the single-ended reference input
// - override bit 0 enables the synthesiser
// - seven-bit trim in bits 6:0, loadable by the calibration engine
// - calibrated trim reads back and may be written back later
// - clearing the reset bit with calibration enabled starts trim search
// - done flag rises after calibration, or at once when disabled
`timescale 1ns/10ps
module spo_synth_ctrl (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    // register port
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic [7:0]                      reg_rdata,
    // configuration pins
    input  wire logic                       pll_enable_pin,
    input  wire logic                       ref_type_pin,
    input  wire logic                       clock_config_pin_zero,
    input  wire logic                       clock_config_pin_one,
    // calibration control and oscillator comparator
    input  wire logic                       osc_calibration_enable,
    input  wire logic                       osc_too_fast,
    output logic                            osc_calibration_done,
    // synthesiser controls
    output logic                            synth_enable,
    output logic                            single_ended_ref_select,
    output logic [1:0]                      first_refout_mode,
    output logic [1:0]                      second_refout_mode,
    output logic                            synth_reset,
    output logic [spo_pkg::SPO_TRIM_W-1:0]  osc_frequency_trim
);

    spo_pkg::spo_override_s                 synth_pin_override;
    logic                                   synth_reset_bit;
    spo_pkg::spo_pins_s                     pin_meta;
    spo_pkg::spo_pins_s                     pin_sync;
    logic [1:0]                             fast_sync;
    logic                                   wr_override;
    logic                                   wr_trim;
    logic                                   wr_reset;
    logic                                   cal_load;
    logic [spo_pkg::SPO_TRIM_W-1:0]         cal_value;
    logic                                   next_enable;
    logic                                   next_se;
    logic [1:0]                             next_first;
    logic [1:0]                             next_second;
    logic [1:0]                             pin_mode;

    // write strobes
    assign wr_override = reg_wr && (reg_addr == spo_pkg::SPO_ADDR_OVERRIDE);
    assign wr_trim     = reg_wr && (reg_addr == spo_pkg::SPO_ADDR_TRIM);
    assign wr_reset    = reg_wr && (reg_addr == spo_pkg::SPO_ADDR_RESET);

    // pins are asynchronous: two flops before anything reads them
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_meta  <= '0;
            pin_sync  <= '0;
            fast_sync <= 2'h0;
        end else begin
            pin_meta  <= {pll_enable_pin, ref_type_pin,
                          clock_config_pin_one, clock_config_pin_zero};
            pin_sync  <= pin_meta;
            fast_sync <= {fast_sync[0], osc_too_fast};
        end
    end

    // override register; reserved bit stored as written
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            synth_pin_override <= spo_pkg::SPO_OVERRIDE_RST;
        end else if (wr_override) begin
            synth_pin_override <= spo_pkg::spo_override_s'(reg_wdata);
        end
    end

    // synthesiser reset bit
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            synth_reset_bit <= spo_pkg::SPO_RESET_BIT_RST;
        end else if (wr_reset) begin
            synth_reset_bit <= reg_wdata[spo_pkg::SPO_RESET_POS];
        end
    end

    // trim register
    // engine loads win; software should not write during a search anyway
    // no load under reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            osc_frequency_trim <= spo_pkg::SPO_TRIM_RST;
        end else if (cal_load && !synth_reset_bit) begin
            osc_frequency_trim <= cal_value;
        end else if (wr_trim) begin
            osc_frequency_trim <= reg_wdata[spo_pkg::SPO_TRIM_MSB:0];
        end
    end

    spo_cal_engine u_cal (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .hold       (synth_reset_bit),
        .cal_enable (osc_calibration_enable),
        .too_fast   (fast_sync[1]),
        .trim_load  (cal_load),
        .trim_value (cal_value),
        .done       (osc_calibration_done)
    );

    // pin or register source
    // both outputs take their mode from the two config pins in pin mode
    assign pin_mode = {pin_sync.cfg_one, pin_sync.cfg_zero};
    always_comb begin
        if (synth_pin_override.enable) begin
            next_enable = synth_pin_override.synth_en;
            next_se     = synth_pin_override.se_select;
            next_first  = synth_pin_override.first_mode;
            next_second = synth_pin_override.second_mode;
        end else begin
            next_enable = pin_sync.pll_enable;
            next_se     = pin_sync.ref_type;
            next_first  = pin_mode;
            next_second = pin_mode;
        end
    end

    // second output gated by the first
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            synth_enable            <= 1'b0;
            single_ended_ref_select <= 1'b0;
            first_refout_mode       <= spo_pkg::SPO_REFOUT_OFF;
            second_refout_mode      <= spo_pkg::SPO_REFOUT_OFF;
            synth_reset             <= 1'b0;
        end else begin
            synth_enable            <= next_enable;
            single_ended_ref_select <= next_se;
            first_refout_mode       <= next_first;
            second_refout_mode      <=
                (next_first == spo_pkg::SPO_REFOUT_OFF) ?
                spo_pkg::SPO_REFOUT_OFF : next_second;
            synth_reset             <= synth_reset_bit;
        end
    end

    // read-back, one cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                spo_pkg::SPO_ADDR_OVERRIDE: reg_rdata <= synth_pin_override;
                spo_pkg::SPO_ADDR_TRIM:  reg_rdata <= {1'b0, osc_frequency_trim};
                spo_pkg::SPO_ADDR_RESET: reg_rdata <= {7'h00, synth_reset_bit};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    // checks
    property p_pin_enable;
        @(posedge clk_sys) disable iff (!nrst)
        !synth_pin_override.enable |=> synth_enable == $past(pin_sync[3]);
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("pin mode enable does not follow pin");

    property p_ovr_enable;
        @(posedge clk_sys) disable iff (!nrst)
        synth_pin_override.enable
            |=> synth_enable == $past(synth_pin_override.synth_en);
    endproperty
    a_ovr_enable: assert property (p_ovr_enable)
        else $error("override enable value not applied");

    property p_ovr_se;
        @(posedge clk_sys) disable iff (!nrst)
        synth_pin_override.enable |=> single_ended_ref_select ==
            $past(synth_pin_override.se_select);
    endproperty
    a_ovr_se: assert property (p_ovr_se)
        else $error("override reference select not applied");

    property p_ovr_first;
        @(posedge clk_sys) disable iff (!nrst)
        synth_pin_override.enable |=> first_refout_mode ==
            $past(synth_pin_override.first_mode);
    endproperty
    a_ovr_first: assert property (p_ovr_first)
        else $error("first output mode not applied");

    property p_ovr_second;
        @(posedge clk_sys) disable iff (!nrst)
        synth_pin_override.enable && synth_pin_override.first_mode != 2'h0
            |=> second_refout_mode == $past(synth_pin_override.second_mode);
    endproperty
    a_ovr_second: assert property (p_ovr_second)
        else $error("second output mode not applied");

    property p_pin_modes;
        @(posedge clk_sys) disable iff (!nrst)
        !synth_pin_override.enable ##1 !synth_pin_override.enable
            |=> first_refout_mode == $past(pin_sync[1:0]);
    endproperty
    a_pin_modes: assert property (p_pin_modes)
        else $error("mode field leaked through in pin mode");

    property p_second_gated;
        @(posedge clk_sys) disable iff (!nrst)
        first_refout_mode == 2'h0 |-> second_refout_mode == 2'h0;
    endproperty
    a_second_gated: assert property (p_second_gated)
        else $error("second output runs without the first");

    property p_hold_trim;
        @(posedge clk_sys) disable iff (!nrst)
        synth_reset_bit && !wr_trim |=> $stable(osc_frequency_trim);
    endproperty
    a_hold_trim: assert property (p_hold_trim)
        else $error("trim changed while held in reset");

    property p_skip_done;
        @(posedge clk_sys) disable iff (!nrst)
        $fell(synth_reset_bit) && !osc_calibration_enable
            |=> ##1 osc_calibration_done;
    endproperty
    a_skip_done: assert property (p_skip_done)
        else $error("done not raised when calibration disabled");

    property p_cal_done;
        @(posedge clk_sys) disable iff (!nrst)
        $fell(synth_reset_bit) && osc_calibration_enable
            ##1 !synth_reset_bit [*8] |-> ##[1:500] osc_calibration_done;
    endproperty
    a_cal_done: assert property (p_cal_done)
        else $error("calibration did not finish in time");

    property p_readback;
        @(posedge clk_sys) disable iff (!nrst)
        reg_rd && reg_addr == spo_pkg::SPO_ADDR_TRIM
            |=> reg_rdata == {1'b0, $past(osc_frequency_trim)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("trim read-back mismatch");

    c_cal_done: cover property (@(posedge clk_sys) disable iff (!nrst)
        osc_calibration_enable && $rose(osc_calibration_done));
    c_override: cover property (@(posedge clk_sys) disable iff (!nrst)
        synth_pin_override.enable && second_refout_mode == 2'h3);
    c_pin_mode: cover property (@(posedge clk_sys) disable iff (!nrst)
        !synth_pin_override.enable && first_refout_mode == 2'h2);

endmodule // spo_synth_ctrl

// ===== logic/spo_pkg.sv
// Purpose: shared constants and carriers for the synthesiser pin-override,
//          oscillator trim and synthesiser reset block
// Assumes: 8-bit register port on the system clock, 50 MHz
// Notes:   settle time of the trim search is a plain default value
package spo_pkg;

    // register offsets on the register port
    localparam logic [7:0] SPO_ADDR_OVERRIDE = 8'h58;
    localparam logic [7:0] SPO_ADDR_TRIM     = 8'h59;
    localparam logic [7:0] SPO_ADDR_RESET    = 8'h5c;

    // reset values
    localparam logic [7:0] SPO_OVERRIDE_RST  = 8'h00;
    localparam logic [6:0] SPO_TRIM_RST      = 7'h00;
    localparam logic       SPO_RESET_BIT_RST = 1'b0;

    // field positions
    localparam int SPO_TRIM_W     = 7;
    localparam int SPO_TRIM_MSB   = 6;
    localparam int SPO_RESET_POS  = 0;

    // divided-reference output modes
    localparam logic [1:0] SPO_REFOUT_OFF  = 2'h0;
    localparam logic [1:0] SPO_REFOUT_DIV1 = 2'h1;
    localparam logic [1:0] SPO_REFOUT_DIV2 = 2'h2;
    localparam logic [1:0] SPO_REFOUT_DIV4 = 2'h3;

    // timing: oscillator settle time per trim step
    localparam int SPO_CLK_NS     = 20;
    localparam int SPO_SETTLE_NS  = 1000;
    localparam int SPO_SETTLE_CYC =
        (SPO_SETTLE_NS + SPO_CLK_NS - 1) / SPO_CLK_NS;
    localparam int SPO_CNT_W      = 8;

    // layout of the pin-override register, msb first
    typedef struct packed {
        logic       enable;       // bit 7
        logic       reserved;     // bit 6
        logic [1:0] second_mode;  // bits 5:4
        logic [1:0] first_mode;   // bits 3:2
        logic       se_select;    // bit 1
        logic       synth_en;     // bit 0
    } spo_override_s;

    // configuration pins after synchronisation
    typedef struct packed {
        logic pll_enable;
        logic ref_type;
        logic cfg_one;
        logic cfg_zero;
    } spo_pins_s;

    // one-hot states of the calibration engine
    typedef enum logic [3:0] {
        SPO_CAL_IDLE   = 4'b0001,
        SPO_CAL_SETTLE = 4'b0010,
        SPO_CAL_DECIDE = 4'b0100,
        SPO_CAL_DONE   = 4'b1000
    } spo_cal_state_e;

endpackage

// ===== logic/spo_cal_engine.sv
// Purpose: oscillator trim search, one trim bit per step, msb first
// Assumes: too_fast already synchronised; hold is the synthesiser reset bit
// Notes:   done rises at once when calibration is disabled
`timescale 1ns/10ps
module spo_cal_engine (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    // control
    input  wire logic                       hold,
    input  wire logic                       cal_enable,
    input  wire logic                       too_fast,
    // trim and status
    output logic                            trim_load,
    output logic [spo_pkg::SPO_TRIM_W-1:0]  trim_value,
    output logic                            done
);

    spo_pkg::spo_cal_state_e                state;
    logic [2:0]                             bit_idx;
    logic [spo_pkg::SPO_CNT_W-1:0]          settle_cnt;

    // held by reset bit
    // search sequencer; hold keeps the engine parked and done low
    always_ff @(posedge clk_sys) begin
        if (!nrst || hold) begin
            state      <= spo_pkg::SPO_CAL_IDLE;
            bit_idx    <= 3'h6;
            settle_cnt <= '0;
            trim_load  <= 1'b0;
            trim_value <= spo_pkg::SPO_TRIM_RST;
            done       <= 1'b0;
        end else begin
            trim_load <= 1'b0;
            case (state)
                spo_pkg::SPO_CAL_IDLE: begin
                    if (cal_enable) begin
                        // start from mid-scale
                        trim_value <= 7'h40;
                        trim_load  <= 1'b1;
                        bit_idx    <= 3'h6;
                        settle_cnt <= '0;
                        state      <= spo_pkg::SPO_CAL_SETTLE;
                    end else begin
                        done  <= 1'b1;
                        state <= spo_pkg::SPO_CAL_DONE;
                    end
                end
                spo_pkg::SPO_CAL_SETTLE: begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt ==
                        8'(spo_pkg::SPO_SETTLE_CYC - 1)) begin
                        state <= spo_pkg::SPO_CAL_DECIDE;
                    end
                end
                spo_pkg::SPO_CAL_DECIDE: begin
                    trim_load  <= 1'b1;
                    settle_cnt <= '0;
                    if (bit_idx == 3'h0) begin
                        // done waits one edge so it meets the final trim
                        trim_value[0] <= ~too_fast;
                        state         <= spo_pkg::SPO_CAL_DONE;
                    end else begin
                        // keep or drop this bit, try the next one
                        trim_value[bit_idx]        <= ~too_fast;
                        trim_value[bit_idx - 3'h1] <= 1'b1;
                        bit_idx                    <= bit_idx - 3'h1;
                        state <= spo_pkg::SPO_CAL_SETTLE;
                    end
                end
                spo_pkg::SPO_CAL_DONE: begin
                    done <= 1'b1;
                end
                default: begin
                    state <= spo_pkg::SPO_CAL_IDLE;
                end
            endcase
        end
    end

endmodule // spo_cal_engine

// ===== bench/spo_osc_model.sv
// Purpose: behavioural oscillator seen by the trim search
// Assumes: a higher trim raises the oscillator frequency
// Notes:   target stands for the frequency the reference asks for
`timescale 1ns/10ps
module spo_osc_model (
    // trim from the block and wanted setting
    input  wire logic [6:0] trim,
    input  wire logic [6:0] target,
    // comparator level back to the block
    output logic            too_fast
);
    // comparator: above target when trim passes it, so search ends on target
    assign too_fast = (trim > target);
endmodule // spo_osc_model

// ===== bench/testbench.sv
// Purpose: self-checking bench for the synthesiser override block
// Assumes: register strobes and pins change on the falling edge
// Notes:   random pins and fields from a fixed seed, corners among them
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    // clock, reset and register port
    logic                   clk_sys;
    logic                   nrst;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [7:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    // pins, calibration and controls
    spo_pkg::spo_pins_s     pins;
    logic                   cal_en;
    logic                   too_fast;
    logic                   cal_done;
    logic                   s_en;
    logic                   s_se;
    logic [1:0]             m_first;
    logic [1:0]             m_second;
    logic                   s_rst;
    logic [6:0]             trim;
    logic [6:0]             target;
    logic [6:0]             held;
    // bench state
    spo_pkg::spo_override_s ovr;
    logic [7:0]             rd;
    logic [7:0]             v;
    int                     fails;
    int                     checks;
    int                     cycles;
    int                     seed;
    int                     i;
    int                     n;

    spo_synth_ctrl spo_synth_ctrl_i (
        .clk_sys                 (clk_sys),
        .nrst                    (nrst),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_rdata               (reg_rdata),
        .pll_enable_pin          (pins.pll_enable),
        .ref_type_pin            (pins.ref_type),
        .clock_config_pin_zero   (pins.cfg_zero),
        .clock_config_pin_one    (pins.cfg_one),
        .osc_calibration_enable  (cal_en),
        .osc_too_fast            (too_fast),
        .osc_calibration_done    (cal_done),
        .synth_enable            (s_en),
        .single_ended_ref_select (s_se),
        .first_refout_mode       (m_first),
        .second_refout_mode      (m_second),
        .synth_reset             (s_rst),
        .osc_frequency_trim      (trim)
    );

    spo_osc_model spo_osc_model_i (
        .trim     (trim),
        .target   (target),
        .too_fast (too_fast)
    );

    // free-running 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // hang guard, well above the roughly two thousand cycles the run needs
    initial cycles = 0;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            close_out();
        end
    end

    task automatic close_out;
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic settle(input int c);
        repeat (c) @(negedge clk_sys);
    endtask

    // one write, strobe held across exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask

    // one read; data sampled one and a half cycles after the taking edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // expected controls: {enable, se select, first mode, second mode}
    function automatic logic [5:0] exp_ctl(spo_pkg::spo_override_s o,
                                           spo_pkg::spo_pins_s p);
        logic [1:0] f;
        logic [1:0] s;
        f = o.enable ? o.first_mode : {p.cfg_one, p.cfg_zero};
        s = o.enable ? o.second_mode : {p.cfg_one, p.cfg_zero};
        if (f == spo_pkg::SPO_REFOUT_OFF) begin
            s = spo_pkg::SPO_REFOUT_OFF;
        end
        return o.enable ? {o.synth_en, o.se_select, f, s}
                        : {p.pll_enable, p.ref_type, f, s};
    endfunction

    task automatic chk_ctl;
        logic [5:0] got;
        got = {s_en, s_se, m_first, m_second};
        `CHK("controls", exp_ctl(ovr, pins), got)
    endtask

    // main sequence
    initial begin
        seed = 32'h9ad098f9;
        fails = 0;
        checks = 0;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pins = 4'h0;
        cal_en = 1'b0;
        target = 7'h00;
        ovr = spo_pkg::SPO_OVERRIDE_RST;
        settle(10);
        nrst = 1'b1;
        settle(3);
        // reset values, unmapped read, done with calibration off
        rd_reg(spo_pkg::SPO_ADDR_OVERRIDE, rd);
        `CHK("override reset", spo_pkg::SPO_OVERRIDE_RST, rd)
        rd_reg(spo_pkg::SPO_ADDR_TRIM, rd);
        `CHK("trim reset", {1'b0, spo_pkg::SPO_TRIM_RST}, rd)
        rd_reg(spo_pkg::SPO_ADDR_RESET, rd);
        `CHK("reset reg reset", 8'h00, rd)
        rd_reg(8'h5a, rd);
        `CHK("unmapped read", 8'h00, rd)
        `CHK("done skipped", 1'b1, cal_done)
        // pin mode: mode writes must not reach the outputs
        for (i = 0; i < 24; i++) begin
            v = 8'($random(seed)) & 8'h3f;
            ovr = v;
            wr(spo_pkg::SPO_ADDR_OVERRIDE, v);
            pins = 4'($random(seed));
            settle(4);
            chk_ctl();
        end
        // override mode: every mode pair first, then random fields
        for (i = 0; i < 40; i++) begin
            v = (8'($random(seed)) & 8'h3f) | 8'h80;
            if (i < 16) begin
                v[5:2] = i[3:0];
            end
            ovr = v;
            wr(spo_pkg::SPO_ADDR_OVERRIDE, v);
            pins = 4'($random(seed));
            settle(4);
            chk_ctl();
            rd_reg(spo_pkg::SPO_ADDR_OVERRIDE, rd);
            `CHK("override readback", v, rd)
        end
        // unmapped write leaves the bank alone
        wr(8'h5a, 8'hff);
        rd_reg(spo_pkg::SPO_ADDR_OVERRIDE, rd);
        `CHK("after unmapped write", v, rd)
        // trim written and read back by software
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'h7f;
            wr(spo_pkg::SPO_ADDR_TRIM, v);
            rd_reg(spo_pkg::SPO_ADDR_TRIM, rd);
            `CHK("trim readback", v, rd)
            `CHK("trim output", v[6:0], trim)
        end
        // calibration runs: both ends of the trim range, then random
        for (i = 0; i < 3; i++) begin
            wr(spo_pkg::SPO_ADDR_RESET, 8'h01);
            settle(3);
            `CHK("reset bit", 1'b1, s_rst)
            `CHK("done under reset", 1'b0, cal_done)
            rd_reg(spo_pkg::SPO_ADDR_RESET, rd);
            `CHK("reset readback", 8'h01, rd)
            cal_en = 1'b1;
            target = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
            held = trim;
            settle(100);
            `CHK("trim held", held, trim)
            `CHK("done held", 1'b0, cal_done)
            wr(spo_pkg::SPO_ADDR_RESET, 8'h00);
            n = 0;
            while (cal_done !== 1'b1 && n < 1000) begin
                settle(1);
                n++;
            end
            `CHK("done after search", 1'b1, cal_done)
            `CHK("trim searched", target, trim)
            `CHK("reset released", 1'b0, s_rst)
            rd_reg(spo_pkg::SPO_ADDR_TRIM, rd);
            `CHK("calibrated readback", {1'b0, target}, rd)
        end
        // saved trim written back with calibration skipped
        held = 7'($random(seed));
        wr(spo_pkg::SPO_ADDR_RESET, 8'h01);
        cal_en = 1'b0;
        wr(spo_pkg::SPO_ADDR_TRIM, {1'b0, held});
        wr(spo_pkg::SPO_ADDR_RESET, 8'h00);
        settle(4);
        `CHK("done skipped again", 1'b1, cal_done)
        `CHK("trim written back", held, trim)
        close_out();
    end
endmodule // testbench
